//--- design/sdc_pkg.sv
package sdc_pkg;
	// geometry of the attached memory
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int BA_W = 2;
	localparam int DQ_W = 16;
	localparam int BE_W = DQ_W / 8;
	localparam int A_W = 12;
	localparam int ADDR_W = ROW_W + BA_W + COL_W;
	localparam int A10_BIT = 10;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_TIMING = 12'h004;
	localparam logic [11:0] OFS_REFRESH = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;

	// control bits
	localparam int CB_EN = 0;
	localparam int CB_FULLPAGE = 1;
	localparam int CB_MULTI = 2;
	localparam int CB_MAPROW = 3;
	localparam int CB_BYTE = 4;
	localparam int CTRL_W = 5;

	// timing fields, cycles of pclk, four bits each
	localparam int TF_W = 4;
	localparam int TF_CL = 0;
	localparam int TF_RCD = 4;
	localparam int TF_RP = 8;
	localparam int TF_RRD = 12;
	localparam int TF_RC = 16;
	localparam int TIM_W = 20;
	localparam logic [TF_W-1:0] CL_MIN = 4'h2;
	localparam logic [TF_W-1:0] CL_MAX = 4'h3;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [TIM_W-1:0] TIMING_RST = 20'h72222;

	// refresh interval, printed as a time, converted at the pclk rate
	localparam int CLK_NS = 25;
	localparam int REF_PERIOD_NS = 15000;
	localparam int REF_CYC_DEF = REF_PERIOD_NS / CLK_NS;
	localparam int REF_W = 16;

	// fixed gaps in cycles
	localparam logic [1:0] COL_GAP = 2'h2;
	localparam logic [1:0] TWR = 2'h2;
	localparam logic [TF_W-1:0] TMRD = 4'h2;

	// mode register fields
	localparam int MR_BL_LSB = 0;
	localparam int MR_CL_LSB = 4;
	localparam logic [2:0] MR_BL_1 = 3'h0;
	localparam logic [2:0] MR_BL_FULL = 3'h7;

	// commands as {cs_n, ras_n, cas_n, we_n}
	typedef logic [3:0] sdc_cmd_t;
	localparam sdc_cmd_t CMD_NOP = 4'h7;
	localparam sdc_cmd_t CMD_ACT = 4'h3;
	localparam sdc_cmd_t CMD_RD = 4'h5;
	localparam sdc_cmd_t CMD_WR = 4'h4;
	localparam sdc_cmd_t CMD_BST = 4'h6;
	localparam sdc_cmd_t CMD_PRE = 4'h2;
	localparam sdc_cmd_t CMD_REF = 4'h1;
	localparam sdc_cmd_t CMD_MRS = 4'h0;

	typedef enum logic [3:0] {
		S_CFG, S_INIT_PRE, S_INIT_REF1, S_INIT_REF2, S_INIT_MRS, S_RUN, S_WAIT
	} sdc_st_e;

	typedef struct packed {
		logic req;
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DQ_W-1:0] wdata;
		logic [BE_W-1:0] be;
	} sdc_host_req_s;

	typedef struct packed {
		logic busy;
		logic rvalid;
		logic [DQ_W-1:0] rdata;
	} sdc_host_rsp_s;

	typedef struct packed {
		sdc_cmd_t cmd;
		logic [BA_W-1:0] ba;
		logic [A_W-1:0] a;
		logic [BE_W-1:0] dqm;
		logic [DQ_W-1:0] dq_out;
		logic dq_oe;
	} sdc_mem_s;

	typedef struct packed {
		sdc_st_e st;
		sdc_st_e ret;
		logic [7:0] wait_cnt;
		logic [REF_W-1:0] ref_cnt;
		logic ref_pend;
		logic [7:0] since_act;
		logic row_open;
		logic [BA_W-1:0] open_ba;
		logic [ROW_W-1:0] open_row;
		logic [1:0] col_gap;
		logic bst_due;
		logic pend;
		logic p_we;
		logic [BA_W-1:0] p_ba;
		logic [ROW_W-1:0] p_row;
		logic [COL_W-1:0] p_col;
		logic [DQ_W-1:0] p_wdata;
		logic [BE_W-1:0] p_be;
		logic [3:0] rd_pipe;
		logic [CTRL_W-1:0] cfg_ctrl;
		logic [TIM_W-1:0] cfg_tim;
		logic [REF_W-1:0] cfg_ref;
		sdc_mem_s mem;
		logic rvalid;
		logic [DQ_W-1:0] rdata;
		logic [31:0] prdata;
	} sdc_state_s;
endpackage

//--- design/sdc_core.sv
// Overview of operation
// (RULE1) configuration registers are loaded before the command machine leaves its idle start
// (RULE2) host address is split into row, bank and column phases on the address pins
// (RULE3) every memory command lasts exactly one clock, then no-operation; in full page mode a burst stop follows each column command directly
// (RULE4) busy is raised while refresh, precharge, activation or other overhead runs
// (RULE5) fixed burst or full page burst is chosen by configuration with read latency
// (RULE6) full page mode never uses column commands with automatic precharge
// (RULE7) gaps between commands come from the configurable timing fields
// (RULE8) a reloading timer raises periodic refresh requests at a programmable interval
// (RULE9) multi-bank mode precharges single banks and uses automatic precharge; the code closes rows with precharge-all before refresh
// (RULE10) multi-bank mode spaces activates to different banks by the bank-to-bank time
// (RULE11) single-bank mode closes rows with precharge-all only
// (RULE12) host pipelines reads; up to latency reads stay in flight awaiting data
// (RULE13) sequential mapping steps through all banks of a row before the row
// (RULE14) row mapping steps through all rows of a bank before the bank
// (RULE15) byte mode drives data mask from byte enables on writes
// (RULE16) two clocks separate successive column commands within an open row
// (RULE17) latency, activate-to-column and precharge settings cover two to three cycles; the code range-checks only the latency field
// (RULE18) address bit ten high closes all banks, low closes the selected bank
// (RULE19) full page bursts are ended by a burst stop command
// (RULE20) a pending refresh is served after the burst, banks closed, before host work
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sdc_core
	import sdc_pkg::*;
#(
	parameter int REF_CYC_RST = REF_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sdc_host_req_s host_req,
	output sdc_host_rsp_s host_rsp,
	output sdc_mem_s mem,
	input wire logic [DQ_W-1:0] mem_dq_in
);
	// refuse a reset interval the refresh counter cannot hold
	if (REF_CYC_RST < 1 || REF_CYC_RST > 65535) begin : g_chk
		$error("refresh interval out of range");
	end
	// the column must sit below the precharge bit, or a column command would close the row
	if (COL_W > A10_BIT) begin : g_chk_col
		$error("column wider than the precharge bit position");
	end
	// row address and precharge bit must fit the multiplexed address pins
	if (ROW_W > A_W || A10_BIT >= A_W) begin : g_chk_row
		$error("row or precharge bit outside the address pins");
	end
	// the host word must cover row, bank and column exactly
	if (ADDR_W != ROW_W + BA_W + COL_W) begin : g_chk_addr
		$error("host address width does not match the memory geometry");
	end
	// the latency field of the mode word must fit the address pins
	if (MR_CL_LSB + 3 > A_W) begin : g_chk_mr
		$error("mode register fields outside the address pins");
	end
	// read latencies index the four-stage read pipe
	if (CL_MAX > 4'h3 || CL_MIN < 4'h1) begin : g_chk_cl
		$error("read latency range exceeds the read pipe");
	end
	// timing fields must fit the configuration word
	if (TF_RC + TF_W > TIM_W) begin : g_chk_tim
		$error("timing fields exceed the timing word");
	end
	// the data mask needs one lane per byte
	if (DQ_W % 8 != 0) begin : g_chk_dq
		$error("data width not a whole number of bytes");
	end

	localparam logic [REF_W-1:0] REF_RST = REF_CYC_RST[REF_W-1:0];

	sdc_state_s s;
	sdc_state_s n;
	logic host_ready;
	logic [TF_W-1:0] t_cl;
	logic [TF_W-1:0] t_rcd;
	logic [TF_W-1:0] t_rp;
	logic [TF_W-1:0] t_rrd;
	logic [TF_W-1:0] t_rc;
	logic [TF_W-1:0] act_gap;
	logic full_page;
	logic multi;
	logic hit;
	logic drained;
	logic [COL_W-1:0] m_col;
	logic [BA_W-1:0] m_ba;
	logic [ROW_W-1:0] m_row;
	logic acc_wr;
	logic acc_rd;
	logic [TF_W-1:0] wr_cl;

	// configuration fields
	assign t_cl = s.cfg_tim[TF_CL +: TF_W];
	assign t_rcd = s.cfg_tim[TF_RCD +: TF_W];
	assign t_rp = s.cfg_tim[TF_RP +: TF_W];
	assign t_rrd = s.cfg_tim[TF_RRD +: TF_W];
	assign t_rc = s.cfg_tim[TF_RC +: TF_W];
	assign full_page = s.cfg_ctrl[CB_FULLPAGE]; // RULE5
	assign multi = s.cfg_ctrl[CB_MULTI];
	assign wr_cl = pwdata[TF_CL +: TF_W];

	// address split by mapping scheme
	always_comb begin
		m_col = host_req.addr[COL_W-1:0]; // RULE2
		if (s.cfg_ctrl[CB_MAPROW]) begin
			m_row = host_req.addr[COL_W +: ROW_W]; // RULE14
			m_ba = host_req.addr[COL_W+ROW_W +: BA_W];
		end else begin
			m_ba = host_req.addr[COL_W +: BA_W]; // RULE13
			m_row = host_req.addr[COL_W+BA_W +: ROW_W];
		end
	end

	// host may hand over a request only while no overhead is due
	assign host_ready = (s.st == S_RUN) && !s.pend && !s.ref_pend; // RULE4
	assign hit = s.row_open && (s.open_ba == s.p_ba) && (s.open_row == s.p_row);
	assign drained = (s.col_gap == 2'h0) && (s.rd_pipe == 4'h0) && !s.bst_due;
	assign act_gap = (multi && (s.p_ba != s.open_ba)) ? t_rrd : t_rc; // RULE10
	assign acc_wr = psel && penable && pwrite;
	assign acc_rd = psel && !penable && !pwrite;

	// next state of the whole block
	always_comb begin
		n = s;
		n.mem.cmd = CMD_NOP; // RULE3
		n.mem.dq_oe = 1'b0;
		n.mem.dqm = '0;
		n.rvalid = 1'b0;
		n.bst_due = 1'b0;
		n.rd_pipe = {s.rd_pipe[2:0], 1'b0};
		if (s.since_act != 8'hFF) begin
			n.since_act = s.since_act + 8'h01;
		end
		if (s.col_gap != 2'h0) begin
			n.col_gap = s.col_gap - 2'h1;
		end
		// read data returns the latency after the read reached the pins
		if (s.rd_pipe[t_cl[1:0]]) begin
			n.rvalid = 1'b1; // RULE12
			n.rdata = mem_dq_in;
		end
		// host request capture
		if (host_req.req && host_ready) begin
			n.pend = 1'b1;
			n.p_we = host_req.we;
			n.p_ba = m_ba;
			n.p_row = m_row;
			n.p_col = m_col;
			n.p_wdata = host_req.wdata;
			n.p_be = host_req.be;
		end
		// command sequencer
		case (s.st)
			S_CFG: begin
				if (s.cfg_ctrl[CB_EN]) begin
					n.st = S_INIT_PRE; // RULE1
				end
			end
			// start-up: close all banks, two refreshes, then the mode word
			S_INIT_PRE: begin
				n.mem.cmd = CMD_PRE;
				n.mem.a = '0;
				n.mem.a[A10_BIT] = 1'b1; // RULE18
				n.st = S_WAIT;
				n.ret = S_INIT_REF1;
				n.wait_cnt = {4'h0, t_rp} - 8'h01; // RULE7
			end
			S_INIT_REF1, S_INIT_REF2: begin
				n.mem.cmd = CMD_REF;
				n.st = S_WAIT;
				n.ret = (s.st == S_INIT_REF1) ? S_INIT_REF2 : S_INIT_MRS;
				n.wait_cnt = {4'h0, t_rc} - 8'h01;
			end
			S_INIT_MRS: begin
				n.mem.cmd = CMD_MRS;
				n.mem.ba = '0;
				n.mem.a = '0;
				n.mem.a[MR_BL_LSB +: 3] = full_page ? MR_BL_FULL : MR_BL_1; // RULE5
				n.mem.a[MR_CL_LSB +: 3] = t_cl[2:0];
				n.st = S_WAIT;
				n.ret = S_RUN;
				n.wait_cnt = {4'h0, TMRD} - 8'h01;
			end
			// working state: burst stop first, then refresh, then host work
			S_RUN: begin
				if (s.bst_due) begin
					n.mem.cmd = CMD_BST; // RULE19
				end else if (s.ref_pend) begin
					if (drained) begin // RULE20
						if (s.row_open) begin
							n.mem.cmd = CMD_PRE;
							n.mem.a[A10_BIT] = 1'b1; // RULE18
							n.row_open = 1'b0;
							n.st = S_WAIT;
							n.ret = S_RUN;
							n.wait_cnt = {4'h0, t_rp} - 8'h01;
						end else if (s.since_act >= {4'h0, t_rc}) begin
							n.mem.cmd = CMD_REF;
							n.ref_pend = 1'b0;
							n.st = S_WAIT;
							n.ret = S_RUN;
							n.wait_cnt = {4'h0, t_rc} - 8'h01;
						end
					end
				end else if (s.pend) begin
					// column command on the open row
					if (hit) begin
						if (s.col_gap == 2'h0) begin
							n.mem.cmd = s.p_we ? CMD_WR : CMD_RD;
							n.mem.ba = s.p_ba;
							n.mem.a = '0;
							n.mem.a[COL_W-1:0] = s.p_col;
							if (multi && !full_page) begin
								n.mem.a[A10_BIT] = 1'b1; // RULE9
								n.row_open = 1'b0;
							end else begin
								n.mem.a[A10_BIT] = 1'b0; // RULE6
							end
							if (s.p_we) begin
								n.mem.dq_out = s.p_wdata;
								n.mem.dq_oe = 1'b1;
								n.mem.dqm = s.cfg_ctrl[CB_BYTE] ? ~s.p_be : '0; // RULE15
							end else begin
								n.rd_pipe[0] = 1'b1; // RULE12
							end
							n.col_gap = s.p_we ? TWR : COL_GAP; // RULE16
							n.bst_due = full_page; // RULE19
							n.pend = 1'b0;
						end
					end else if (s.row_open) begin
						// close the open row once column traffic has drained
						if (drained) begin
							n.mem.cmd = CMD_PRE;
							n.mem.ba = s.open_ba;
							n.mem.a[A10_BIT] = !multi; // RULE11
							n.row_open = 1'b0;
							n.st = S_WAIT;
							n.ret = S_RUN;
							n.wait_cnt = {4'h0, t_rp} - 8'h01;
						end
					end else if (s.since_act >= {4'h0, act_gap}) begin
						// open the row once the activate spacing has passed
						n.mem.cmd = CMD_ACT; // RULE10
						n.mem.ba = s.p_ba;
						n.mem.a = s.p_row;
						n.row_open = 1'b1;
						n.open_ba = s.p_ba;
						n.open_row = s.p_row;
						n.since_act = 8'h00;
						n.st = S_WAIT;
						n.ret = S_RUN;
						n.wait_cnt = {4'h0, t_rcd} - 8'h01; // RULE7
					end
				end
			end
			// count down the gap set by the last command
			S_WAIT: begin
				if (s.wait_cnt <= 8'h01) begin
					n.st = s.ret;
				end else begin
					n.wait_cnt = s.wait_cnt - 8'h01;
				end
			end
			default: begin
				n.st = S_CFG;
			end
		endcase
		// refresh interval timer; its set wins over the clear above
		if (s.st != S_CFG) begin
			if (s.ref_cnt == '0) begin
				// reload one short so the request repeats every cfg_ref cycles
				n.ref_cnt = s.cfg_ref - 16'h0001; // RULE8
				n.ref_pend = 1'b1;
			end else begin
				n.ref_cnt = s.ref_cnt - 16'h0001;
			end
		end
		// register writes in the access phase
		if (acc_wr) begin
			case (paddr)
				OFS_CTRL: begin
					if (s.st == S_CFG) begin
						n.cfg_ctrl = pwdata[CTRL_W-1:0]; // RULE1
					end
				end
				OFS_TIMING: begin
					if (s.st == S_CFG && wr_cl >= CL_MIN && wr_cl <= CL_MAX) begin
						n.cfg_tim = pwdata[TIM_W-1:0]; // RULE17
					end
				end
				OFS_REFRESH: begin
					if (pwdata[REF_W-1:0] != '0) begin
						n.cfg_ref = pwdata[REF_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// read data loads in the setup phase
		if (acc_rd) begin
			case (paddr)
				OFS_CTRL: n.prdata = {27'h0, s.cfg_ctrl};
				OFS_TIMING: n.prdata = {12'h0, s.cfg_tim};
				OFS_REFRESH: n.prdata = {16'h0, s.cfg_ref};
				OFS_STATUS: n.prdata = {24'h0, s.ref_pend, s.row_open, !host_ready, 1'b0, s.st};
				default: n.prdata = 32'h0000_0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.st <= S_CFG;
			s.ret <= S_CFG;
			s.mem.cmd <= CMD_NOP;
			s.cfg_ctrl <= CTRL_RST;
			s.cfg_tim <= TIMING_RST;
			s.cfg_ref <= REF_RST;
			s.ref_cnt <= REF_RST - 16'h0001;
			s.since_act <= 8'hFF;
		end else begin
			s <= n;
		end
	end

	// bus answer and outputs
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr != OFS_CTRL) && (paddr != OFS_TIMING) &&
		(paddr != OFS_REFRESH) && (paddr != OFS_STATUS);
	assign prdata = s.prdata;
	assign host_rsp.busy = !host_ready; // RULE4
	assign host_rsp.rvalid = s.rvalid;
	assign host_rsp.rdata = s.rdata;
	assign mem = s.mem;
endmodule
`default_nettype wire

//--- testbench/sdc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_monitor
	import sdc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire sdc_host_rsp_s host_rsp,
	input wire sdc_mem_s mem
);
	logic [CTRL_W-1:0] ctl;
	logic [2:0] cl;
	logic col;
	logic ovh;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// control word as software wrote it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl <= '0;
		else if (psel && penable && pwrite && paddr == OFS_CTRL)
			ctl <= pwdata[CTRL_W-1:0];
	end
	// read latency as the controller programmed it into the memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cl <= '0;
		else if (mem.cmd == CMD_MRS)
			cl <= mem.a[MR_CL_LSB +: 3];
	end
	// column and overhead command classes
	assign col = mem.cmd inside {CMD_RD, CMD_WR};
	assign ovh = mem.cmd inside {CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS};
	property p_cfg; mem.cmd != CMD_NOP |-> ctl[CB_EN]; endproperty
	a_cfg: assert property (p_cfg) else $error("command before enable");
	property p_pulse; ovh |=> mem.cmd == CMD_NOP; endproperty
	a_pulse: assert property (p_pulse) else $error("command held");
	property p_busy; ovh |-> host_rsp.busy; endproperty
	a_busy: assert property (p_busy) else $error("busy low in overhead");
	property p_gap; col |=> !col ##1 !col; endproperty
	a_gap: assert property (p_gap) else $error("column gap short");
	property p_rlat; mem.cmd == CMD_RD && {1'b0, cl} == CL_MIN |-> ##3 host_rsp.rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read data late");
	property p_prea; mem.cmd == CMD_PRE && !ctl[CB_MULTI] |-> mem.a[A10_BIT]; endproperty
	a_prea: assert property (p_prea) else $error("single bank precharge");
	property p_fp; col && ctl[CB_FULLPAGE] |-> !mem.a[A10_BIT]; endproperty
	a_fp: assert property (p_fp) else $error("autoprecharge in full page");
	property p_bst; mem.cmd == CMD_RD && ctl[CB_FULLPAGE] |=> mem.cmd == CMD_BST; endproperty
	a_bst: assert property (p_bst) else $error("no burst stop");
	property p_ap; col && ctl[CB_MULTI] && !ctl[CB_FULLPAGE] |-> mem.a[A10_BIT]; endproperty
	a_ap: assert property (p_ap) else $error("no autoprecharge");
endmodule
`default_nettype wire

//--- testbench/sdc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_mem_model
	import sdc_pkg::*;
(
	input wire logic pclk,
	input wire sdc_mem_s mem,
	output logic [DQ_W-1:0] dq
);
	logic [DQ_W-1:0] store [logic [ADDR_W-1:0]];
	logic [ROW_W-1:0] row [1<<BA_W];
	logic [DQ_W-1:0] s0, s1, w;
	logic [DQ_W-1:0] last = '0;
	logic v0 = 0;
	logic v1 = 0;
	logic [ADDR_W-1:0] k;
	// cell address from bank, open row and column
	assign k = {mem.ba, row[mem.ba], mem.a[COL_W-1:0]};
	// data two clocks after the read, a toggling pattern otherwise
	assign dq = v1 ? s1 : ~last;
	// open rows, masked writes, read pipe
	always @(posedge pclk) begin
		w = store.exists(k) ? store[k] : '0;
		for (int b = 0; b < BE_W; b++)
			if (!mem.dqm[b]) w[b*8+:8] = mem.dq_out[b*8+:8];
		if (mem.cmd == CMD_WR) store[k] = w;
		if (mem.cmd == CMD_ACT) row[mem.ba] <= mem.a;
		v0 <= mem.cmd == CMD_RD;
		s0 <= store.exists(k) ? store[k] : '0;
		v1 <= v0;
		s1 <= s0;
		last <= v1 ? s1 : ~last;
	end
endmodule
`default_nettype wire

//--- testbench/sdc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_core_test
	import sdc_pkg::*;
;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	sdc_host_req_s host_req = '0;
	sdc_host_rsp_s host_rsp;
	sdc_mem_s mem;
	logic [DQ_W-1:0] dq, hd;
	int errors = 0;
	int samples_checked = 0;
	sdc_core #(.REF_CYC_RST(64)) i_sdc_core(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_req(host_req), .host_rsp(host_rsp), .mem(mem), .mem_dq_in(dq));
	sdc_mem_model i_sdc_mem_model(.pclk(pclk), .mem(mem), .dq(dq));
	// clock
	initial forever #12.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rst;
		presetn <= 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
	endtask
	task automatic en(input logic [4:0] c);
		apb(1, OFS_CTRL, {27'h0, c});
		for (int i = 0; i < 300; i++) begin
			@(posedge pclk);
			if (!host_rsp.busy) break;
		end
		chk(host_rsp.busy, 0);
	endtask
	task automatic hacc(input logic w, input logic [21:0] a, input logic [15:0] d, input logic [1:0] b);
		host_req <= '{1'b1, w, a, d, b};
		for (int i = 0; i < 300; i++) begin
			@(posedge pclk);
			if (!host_rsp.busy) break;
		end
		chk(host_rsp.busy, 0);
		host_req.req <= 0;
		if (!w) begin
			hd = 'x;
			for (int i = 0; i < 40; i++) begin
				@(negedge pclk);
				if (host_rsp.rvalid === 1'b1) break;
			end
			hd = host_rsp.rdata;
		end
		@(posedge pclk);
	endtask
	task automatic t_regs;
		rst();
		apb(0, OFS_TIMING, 0);
		chk(rd, TIMING_RST);
		apb(0, OFS_REFRESH, 0);
		chk(rd, 64);
		apb(1, OFS_TIMING, 32'h00072223);
		apb(1, OFS_TIMING, 32'h00072224);
		apb(0, OFS_TIMING, 0);
		chk(rd, 32'h00072223);
		apb(1, OFS_TIMING, TIMING_RST);
		apb(0, 12'h010, 0);
		chk(er, 1);
		chk(rd, 0);
		$display("register test done");
	endtask
	task automatic t_seq;
		rst();
		en(5'h01);
		hacc(1, 22'h000105, 16'hA5C3, 2'h3);
		hacc(1, 22'h000405, 16'h5A3C, 2'h3);
		hacc(0, 22'h000105, 0, 2'h3);
		chk(hd, 16'hA5C3);
		hacc(0, 22'h000105, 0, 2'h3);
		chk(hd, 16'hA5C3);
		chk(i_sdc_mem_model.store[{2'h1, 12'h000, 8'h05}], 16'hA5C3);
		chk(i_sdc_mem_model.store[{2'h0, 12'h001, 8'h05}], 16'h5A3C);
		$display("sequential test done");
	endtask
	task automatic t_page;
		rst();
		en(5'h0F);
		hacc(1, 22'h100105, 16'h0F0F, 2'h3);
		hacc(0, 22'h100105, 0, 2'h3);
		chk(hd, 16'h0F0F);
		chk(i_sdc_mem_model.store[{2'h1, 12'h001, 8'h05}], 16'h0F0F);
		$display("full page test done");
	endtask
	task automatic t_bytes;
		rst();
		en(5'h15);
		hacc(1, 22'h000105, 16'h1234, 2'h3);
		hacc(1, 22'h000205, 16'h7777, 2'h3);
		hacc(1, 22'h000105, 16'hABCD, 2'h1);
		hacc(0, 22'h000105, 0, 2'h3);
		chk(hd, 16'h12CD);
		hacc(0, 22'h000205, 0, 2'h3);
		chk(hd, 16'h7777);
		$display("byte mask test done");
	endtask
	task automatic t_refresh;
		int n;
		for (int j = 0; j < 3; j++) begin
			n = 1;
			@(posedge pclk);
			while (mem.cmd !== CMD_REF && n < 300) begin
				@(posedge pclk);
				n++;
			end
		end
		chk(n, 64);
		$display("refresh test done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		t_regs();
		t_seq();
		t_page();
		t_bytes();
		t_refresh();
		end_sim();
	end
	// watchdog
	initial begin
		#500000;
		errors++;
		end_sim();
	end
endmodule
bind sdc_core sdc_monitor i_sdc_monitor(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .host_rsp(host_rsp), .mem(mem));
`default_nettype wire
